// ===== design/link_behavior_control_reg.sv
// link behaviour control register with Avalon-MM slave and registered link outputs
`timescale 1ns/1ps
`include "link_ctrl_cfg.svh"

// Operation
// - writing one to bit 15 enters far-end link-drop mode; resets zero, read-write.
// - in that mode under forced 100, transmitter is shut off when link is lost.
// - bit 6 set shortens parallel-detect link-up; clear means normal parallel detection.
// - bit 6 is set by hardware whenever fast or robust crossover mode is selected.
// - bit 5 set forces full duplex against a forced-100 partner under autoneg or forced 100.
// - bit 5 clear leaves duplex choice to the standard resolution.
// - bit 4 set lights link lamp only at 100 full duplex; clear, any link.
// - qualified link lamp ignores the activity blink setting and never blinks.
// - bit 3 set isolates MII outputs on a 100 half-duplex link; clear, normal.
// - bit 2 controls idle symbol-error flagging; resets to one, read-write.
// - bit 2 one enables idle symbol-error detection, zero disables it.
module link_behavior_control_reg
	import link_ctrl_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,

	// avalon-mm slave
	input wire logic [`LC_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [`LC_DATA_W-1:0] writedata,
	input wire logic [`LC_BE_W-1:0] byteenable,
	output logic [`LC_DATA_W-1:0] readdata,
	output logic waitrequest,

	// crossover mode and led settings from neighbouring registers
	input wire logic fast_mdix_sel,
	input wire logic robust_mdix_sel,
	input wire logic led_blink_en,

	// link state from the core
	input wire logic link_up,
	input wire logic speed_100,
	input wire logic forced_100,
	input wire logic autoneg_en,
	input wire logic partner_forced_100,
	input wire logic ieee_full_duplex,
	input wire logic activity_blink,
	input wire logic rx_idle_state,
	input wire logic rx_symbol_error,

	// link control outputs
	output logic tx_disable,
	output logic fast_pd_en,
	output logic full_duplex,
	output logic link_led,
	output logic mii_isolate,
	output logic idle_symerr_det_en,
	output logic idle_symerr_flag,
	output logic odd_nibble_det_dis,
	output logic rmii_rx_clk_sel
);

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	link_ctrl_if lc ();

	bus_state_type bus_state_q;
	bus_state_type bus_state_d;
	logic waitrequest_q;
	logic waitrequest_d;
	logic [`LC_DATA_W-1:0] readdata_q;
	logic [`LC_DATA_W-1:0] readdata_d;

	logic [`LC_REG_W-1:0] ctrl_q;
	logic [`LC_REG_W-1:0] ctrl_d;
	logic [`LC_REG_W-1:0] ctrl_merged;

	logic tx_disable_q;
	logic tx_disable_d;
	logic fast_pd_en_q;
	logic fast_pd_en_d;
	logic full_duplex_q;
	logic full_duplex_d;
	logic link_led_q;
	logic link_led_d;
	logic mii_isolate_q;
	logic mii_isolate_d;
	logic idle_det_q;
	logic idle_det_d;
	logic idle_flag_q;
	logic idle_flag_d;
	logic odd_nibble_q;
	logic odd_nibble_d;
	logic rmii_clk_q;
	logic rmii_clk_d;

	logic [`LC_STATUS_W-1:0] status_view;
	logic write_accept;
	logic ctrl_hit;
	logic status_hit;
	logic auto_fast_pd;
	logic ctrl_write;
	logic [`LC_DATA_W-1:0] read_word;

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	always_comb begin
		ctrl_hit = 1'b0;
		status_hit = 1'b0;
		case (address)
			`LC_CTRL_ADDR: begin
				ctrl_hit = 1'b1;
			end
			`LC_STATUS_ADDR: begin
				status_hit = 1'b1;
			end
			default: begin
				// unmapped places: nothing selected, same bus timing
				ctrl_hit = 1'b0;
			end
		endcase
	end
	// the write lands at the edge where the master sees waitrequest low
	assign write_accept = (bus_state_q == bus_answer) & write;
	// status writes fall through here and are dropped
	assign ctrl_write = write_accept & ctrl_hit;

	// ----------------------------------------
	// byte lane merge
	// ----------------------------------------
	// only the two low lanes carry the 16-bit register; upper lanes are dropped
	genvar lane;
	generate
		for (lane = 0; lane < `LC_REG_W / 8; lane = lane + 1) begin : g_lane
			assign ctrl_merged[8*lane +: 8] = byteenable[lane] ? writedata[8*lane +: 8] : ctrl_q[8*lane +: 8];
		end
	endgenerate

	// ----------------------------------------
	// policy logic
	// ----------------------------------------
	assign lc.far_end_drop = ctrl_q[`LC_BIT_FAR_END_DROP];
	assign lc.ext_fd = ctrl_q[`LC_BIT_EXT_FD];
	assign lc.qual_led = ctrl_q[`LC_BIT_QUAL_LED];
	assign lc.iso_hd = ctrl_q[`LC_BIT_ISO_HD];
	assign lc.idle_symerr = ctrl_q[`LC_BIT_IDLE_SYMERR];
	assign lc.link_up = link_up;
	assign lc.speed_100 = speed_100;
	assign lc.forced_100 = forced_100;
	assign lc.autoneg_en = autoneg_en;
	assign lc.partner_forced_100 = partner_forced_100;
	assign lc.ieee_full_duplex = ieee_full_duplex;
	assign lc.blink_en = led_blink_en;
	assign lc.activity_blink = activity_blink;
	assign lc.idle_state = rx_idle_state;
	assign lc.symbol_error = rx_symbol_error;

	link_policy u_policy (
		.lc(lc.policy_side)
	);

	// ----------------------------------------
	// control register next value
	// ----------------------------------------
	assign auto_fast_pd = fast_mdix_sel | robust_mdix_sel;

	always_comb begin
		ctrl_d = ctrl_q;
		if (ctrl_write) begin
			// all sixteen bits are writable, reserved ones included
			ctrl_d = ctrl_merged;
		end
		// hardware set wins over a software clear in the same cycle
		if (auto_fast_pd) begin
			ctrl_d[`LC_BIT_FAST_PD] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			ctrl_q <= `LC_CTRL_RESET;
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// ----------------------------------------
	// bus handshake
	// ----------------------------------------
	always_comb begin
		status_view = '0;
		status_view[`LC_ST_LINK_UP] = link_up;
		status_view[`LC_ST_SPEED_100] = speed_100;
		status_view[`LC_ST_FULL_DUPLEX] = full_duplex_q;
		status_view[`LC_ST_LINK_LED] = link_led_q;
		status_view[`LC_ST_MII_ISOLATE] = mii_isolate_q;
		status_view[`LC_ST_TX_DISABLE] = tx_disable_q;
		status_view[`LC_ST_FAST_PD] = fast_pd_en_q;
		status_view[`LC_ST_IDLE_DET] = idle_det_q;
	end

	// the word a read returns; unmapped places read as zero
	always_comb begin
		read_word = '0;
		if (ctrl_hit) begin
			read_word = {{(`LC_DATA_W-`LC_REG_W){1'b0}}, ctrl_q};
		end else if (status_hit) begin
			read_word = {{(`LC_DATA_W-`LC_STATUS_W){1'b0}}, status_view};
		end
	end

	always_comb begin
		bus_state_d = bus_state_q;
		waitrequest_d = waitrequest_q;
		readdata_d = readdata_q;
		case (bus_state_q)
			bus_idle: begin
				if (read || write) begin
					// one wait state, so read data is settled before it is taken
					bus_state_d = bus_answer;
					waitrequest_d = 1'b0;
					// a write leaves zero behind, so no stale word lingers
					readdata_d = read ? read_word : '0;
				end
			end
			bus_answer: begin
				bus_state_d = bus_idle;
				waitrequest_d = 1'b1;
			end
			default: begin
				bus_state_d = bus_idle;
				waitrequest_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			bus_state_q <= bus_idle;
			waitrequest_q <= 1'b1;
			readdata_q <= '0;
		end else begin
			bus_state_q <= bus_state_d;
			waitrequest_q <= waitrequest_d;
			readdata_q <= readdata_d;
		end
	end

	// ----------------------------------------
	// registered link outputs
	// ----------------------------------------
	// one cycle of latency on every decision, traded for glitch-free outputs
	always_comb begin
		tx_disable_d = lc.tx_disable;
		fast_pd_en_d = ctrl_q[`LC_BIT_FAST_PD];
		full_duplex_d = lc.full_duplex;
		link_led_d = lc.link_led;
		mii_isolate_d = lc.mii_isolate;
		idle_det_d = ctrl_q[`LC_BIT_IDLE_SYMERR];
		idle_flag_d = lc.idle_symerr_flag;
		odd_nibble_d = ctrl_q[1];
		rmii_clk_d = ctrl_q[0];
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			tx_disable_q <= 1'b0;
			fast_pd_en_q <= 1'b0;
			full_duplex_q <= 1'b0;
			link_led_q <= 1'b0;
			mii_isolate_q <= 1'b0;
			idle_det_q <= 1'b1;
			idle_flag_q <= 1'b0;
			odd_nibble_q <= 1'b0;
			rmii_clk_q <= 1'b0;
		end else begin
			tx_disable_q <= tx_disable_d;
			fast_pd_en_q <= fast_pd_en_d;
			full_duplex_q <= full_duplex_d;
			link_led_q <= link_led_d;
			mii_isolate_q <= mii_isolate_d;
			idle_det_q <= idle_det_d;
			idle_flag_q <= idle_flag_d;
			odd_nibble_q <= odd_nibble_d;
			rmii_clk_q <= rmii_clk_d;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign readdata = readdata_q;
	assign waitrequest = waitrequest_q;
	assign tx_disable = tx_disable_q;
	assign fast_pd_en = fast_pd_en_q;
	assign full_duplex = full_duplex_q;
	assign link_led = link_led_q;
	assign mii_isolate = mii_isolate_q;
	assign idle_symerr_det_en = idle_det_q;
	assign idle_symerr_flag = idle_flag_q;
	assign odd_nibble_det_dis = odd_nibble_q;
	assign rmii_rx_clk_sel = rmii_clk_q;

endmodule

// ===== design/link_ctrl_cfg.svh
// constants for the link behaviour control register and its bus slave
`ifndef LINK_CTRL_CFG_SVH
`define LINK_CTRL_CFG_SVH

// ----------------------------------------
// bus geometry
// ----------------------------------------
`define LC_ADDR_W 8
`define LC_DATA_W 32
`define LC_BE_W 4
`define LC_REG_W 16

// ----------------------------------------
// register indices and byte addresses
// ----------------------------------------
`define LC_CTRL_INDEX 8'h0a
`define LC_CTRL_ADDR 8'h28
`define LC_STATUS_ADDR 8'h40

// ----------------------------------------
// field positions
// ----------------------------------------
`define LC_BIT_FAR_END_DROP 15
`define LC_BIT_FAST_PD 6
`define LC_BIT_EXT_FD 5
`define LC_BIT_QUAL_LED 4
`define LC_BIT_ISO_HD 3
`define LC_BIT_IDLE_SYMERR 2

// status register field positions
`define LC_ST_LINK_UP 0
`define LC_ST_SPEED_100 1
`define LC_ST_FULL_DUPLEX 2
`define LC_ST_LINK_LED 3
`define LC_ST_MII_ISOLATE 4
`define LC_ST_TX_DISABLE 5
`define LC_ST_FAST_PD 6
`define LC_ST_IDLE_DET 7

// ----------------------------------------
// reset values and status width
// ----------------------------------------
`define LC_CTRL_RESET 16'h0104
`define LC_STATUS_W 8

`endif

// ===== design/link_ctrl_if.sv
// signals between the register holder and the link policy logic
`timescale 1ns/1ps

interface link_ctrl_if;
	// register fields
	logic far_end_drop;
	logic ext_fd;
	logic qual_led;
	logic iso_hd;
	logic idle_symerr;
	// link state from the core, and the led blink setting
	logic link_up;
	logic speed_100;
	logic forced_100;
	logic autoneg_en;
	logic partner_forced_100;
	logic ieee_full_duplex;
	logic blink_en;
	logic activity_blink;
	logic idle_state;
	logic symbol_error;
	// decisions
	logic tx_disable;
	logic full_duplex;
	logic link_led;
	logic mii_isolate;
	logic idle_symerr_flag;

	modport reg_side (
		output far_end_drop, ext_fd, qual_led, iso_hd, idle_symerr,
		output link_up, speed_100, forced_100, autoneg_en, partner_forced_100,
		output ieee_full_duplex, blink_en, activity_blink, idle_state, symbol_error,
		input tx_disable, full_duplex, link_led, mii_isolate, idle_symerr_flag
	);

	modport policy_side (
		input far_end_drop, ext_fd, qual_led, iso_hd, idle_symerr,
		input link_up, speed_100, forced_100, autoneg_en, partner_forced_100,
		input ieee_full_duplex, blink_en, activity_blink, idle_state, symbol_error,
		output tx_disable, full_duplex, link_led, mii_isolate, idle_symerr_flag
	);
endinterface

// ===== design/link_ctrl_pkg.sv
// types shared by the link behaviour control block
package link_ctrl_pkg;

	typedef enum logic {
		bus_idle,
		bus_answer
	} bus_state_type;

endpackage

// ===== design/link_policy.sv
// combinational link policy driven by the control register fields
`timescale 1ns/1ps

module link_policy (
	// fields in, decisions out
	link_ctrl_if.policy_side lc
);

	// ----------------------------------------
	// duplex and transmitter
	// ----------------------------------------
	logic ext_case;
	always_comb begin
		ext_case = lc.ext_fd & (lc.autoneg_en | lc.forced_100) & lc.partner_forced_100;
		// without the extension the standard resolution result is passed through
		lc.full_duplex = ext_case | lc.ieee_full_duplex;
		// only meaningful in forced 100 operation; the far end then sees its link fail
		lc.tx_disable = lc.far_end_drop & lc.forced_100 & ~lc.link_up;
	end

	// ----------------------------------------
	// indicator, isolation, idle errors
	// ----------------------------------------
	always_comb begin
		if (lc.qual_led) begin
			// blink setting ignored so the lamp means 100 full duplex only
			lc.link_led = lc.link_up & lc.speed_100 & lc.full_duplex;
		end else begin
			lc.link_led = lc.link_up & ~(lc.blink_en & lc.activity_blink);
		end
		lc.mii_isolate = lc.iso_hd & lc.link_up & lc.speed_100 & ~lc.full_duplex;
		lc.idle_symerr_flag = lc.idle_symerr & lc.idle_state & lc.symbol_error;
	end

endmodule

// ===== tb/link_ctrl_chk.sv
// concurrent checks on the link behaviour control register ports
`timescale 1ns/1ps

module link_ctrl_chk (
	// clock and reset
	input wire logic ref_clk,
	input wire logic sys_rst,
	// bus handshake
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	// inputs
	input wire logic fast_mdix_sel,
	input wire logic robust_mdix_sel,
	input wire logic link_up,
	input wire logic speed_100,
	input wire logic forced_100,
	input wire logic ieee_full_duplex,
	input wire logic rx_idle_state,
	input wire logic rx_symbol_error,
	// outputs
	input wire logic tx_disable,
	input wire logic fast_pd_en,
	input wire logic full_duplex,
	input wire logic link_led,
	input wire logic mii_isolate,
	input wire logic idle_symerr_flag
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	tx_off_cause_a: assert property (tx_disable |-> $past(forced_100 && !link_up))
		else $error("transmitter off without forced 100 link loss");
	iso_hd_only_a: assert property (mii_isolate |-> !full_duplex && $past(link_up && speed_100))
		else $error("isolation outside a 100 half duplex link");
	led_needs_link_a: assert property (link_led |-> $past(link_up))
		else $error("link lamp lit without link");
	fd_follows_ieee_a: assert property (ieee_full_duplex |=> full_duplex)
		else $error("standard full duplex lost");
	fast_pd_set_a: assert property ((fast_mdix_sel || robust_mdix_sel) |-> ##[1:2] fast_pd_en)
		else $error("crossover mode did not set fast link-up");
	idle_flag_cause_a: assert property (idle_symerr_flag |-> $past(rx_idle_state && rx_symbol_error))
		else $error("idle symbol error flag without cause");
	bus_answer_a: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("request not answered after one wait state");
	bus_one_wait_a: assert property ($fell(waitrequest) |=> waitrequest)
		else $error("waitrequest low longer than one cycle");
endmodule

bind link_behavior_control_reg link_ctrl_chk link_ctrl_chk_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.read(read), .write(write), .waitrequest(waitrequest), .fast_mdix_sel(fast_mdix_sel),
	.robust_mdix_sel(robust_mdix_sel), .link_up(link_up), .speed_100(speed_100), .forced_100(forced_100),
	.ieee_full_duplex(ieee_full_duplex), .rx_idle_state(rx_idle_state), .rx_symbol_error(rx_symbol_error),
	.tx_disable(tx_disable), .fast_pd_en(fast_pd_en), .full_duplex(full_duplex), .link_led(link_led),
	.mii_isolate(mii_isolate), .idle_symerr_flag(idle_symerr_flag));

// ===== tb/tb.sv
// self-checking bench for the link behaviour control register
`timescale 1ns/1ps
`include "link_ctrl_cfg.svh"

module tb;
	logic ref_clk = 0, sys_rst = 1, read = 0, write = 0, fast_sel = 0, robust_sel = 0;
	logic [7:0] address = 0;
	logic [31:0] writedata = 0, readdata, q;
	logic [3:0] byteenable = 0;
	logic waitrequest;
	logic [9:0] lk = 0;
	logic [8:0] outs, e;
	logic [15:0] ctrl, d;
	integer n_fail = 0, n_checks = 0, cyc = 0, seed = 15, i, j;

	always #20 ref_clk = ~ref_clk;

	link_behavior_control_reg link_behavior_control_reg_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
		.readdata(readdata), .waitrequest(waitrequest), .fast_mdix_sel(fast_sel), .robust_mdix_sel(robust_sel),
		.led_blink_en(lk[9]), .link_up(lk[8]), .speed_100(lk[7]), .forced_100(lk[6]), .autoneg_en(lk[5]),
		.partner_forced_100(lk[4]), .ieee_full_duplex(lk[3]), .activity_blink(lk[2]), .rx_idle_state(lk[1]),
		.rx_symbol_error(lk[0]), .tx_disable(outs[8]), .fast_pd_en(outs[7]), .full_duplex(outs[6]),
		.link_led(outs[5]), .mii_isolate(outs[4]), .idle_symerr_det_en(outs[3]), .idle_symerr_flag(outs[2]),
		.odd_nibble_det_dis(outs[1]), .rmii_rx_clk_sel(outs[0]));

	// outputs expected one cycle after the inputs and the register
	function automatic logic [8:0] exp_out(logic [15:0] c, logic [9:0] v);
		logic bl, lu, sp, f1, an, pf, ie, ab, id, se, fd;
		{bl, lu, sp, f1, an, pf, ie, ab, id, se} = v;
		fd = (c[5] & (an | f1) & pf) | ie;
		return {c[15] & f1 & !lu, c[6], fd, c[4] ? lu & sp & fd : lu & !(bl & ab), c[3] & lu & sp & !fd,
			c[2], c[2] & id & se, c[1], c[0]};
	endfunction

	task automatic tally_and_finish;
		if (n_fail == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected register at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_out(input logic [8:0] got, input logic [8:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected outputs at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// holds the request until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] be);
		@(posedge ref_clk);
		read <= !wr;
		write <= wr;
		address <= a;
		writedata <= wd;
		byteenable <= be;
		do @(posedge ref_clk); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask

	// merges written lanes into the shadow copy
	task automatic wr_ctrl(input logic [15:0] v, input logic [3:0] be);
		bus(1'b1, `LC_CTRL_ADDR, {16'hffff, v}, be);
		if (be[0]) ctrl[7:0] = v[7:0];
		if (be[1]) ctrl[15:8] = v[15:8];
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 6000) begin
			n_fail++;
			tally_and_finish;
		end
	end

	initial begin
		repeat (3) @(posedge ref_clk);
		sys_rst <= 1'b0;
		ctrl = 16'h0104;
		bus(1'b0, `LC_CTRL_ADDR, 32'h0000_0000, 4'hf);
		chk_reg(q, 32'h0000_0104);
		// read-modify-write: set far-end drop, keep the reserved value
		wr_ctrl(q[15:0] | 16'h8000, 4'h3);
		bus(1'b0, `LC_CTRL_ADDR, 32'h0000_0000, 4'hf);
		chk_reg(q, 32'h0000_8104);
		// unmapped place: write ignored, read as zero
		bus(1'b1, 8'h30, 32'hffff_ffff, 4'hf);
		bus(1'b0, 8'h30, 32'h0000_0000, 4'hf);
		chk_reg(q, 32'h0000_0000);
		// random writes with lane enables, then read back
		for (i = 0; i < 24; i++) begin
			d = 16'($random(seed));
			wr_ctrl(d, {2'b00, i == 0 ? 2'b11 : 2'($random(seed))});
			bus(1'b0, `LC_CTRL_ADDR, 32'h0000_0000, 4'hf);
			chk_reg(q, {16'h0000, ctrl});
		end
		// outputs against random link states under varied settings
		for (i = 0; i < 10; i++) begin
			d = 16'($random(seed));
			wr_ctrl(i == 0 ? 16'h803c : (i == 1 ? 16'h0018 : d), 4'h3);
			for (j = 0; j < 16; j++) begin
				@(posedge ref_clk);
				lk <= 10'($random(seed));
				@(posedge ref_clk);
				@(negedge ref_clk);
				chk_out(outs, exp_out(ctrl, lk));
			end
			// status word mirrors the registered decisions and the raw link state
			bus(1'b0, `LC_STATUS_ADDR, 32'h0000_0000, 4'hf);
			e = exp_out(ctrl, lk);
			chk_reg(q, {24'h00_0000, e[3], e[7], e[8], e[4], e[5], e[6], lk[7], lk[8]});
		end
		// either crossover mode sets fast link-up, beating a software clear
		for (i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			{fast_sel, robust_sel} <= i ? 2'b01 : 2'b10;
			wr_ctrl(16'h0104, 4'h3);
			bus(1'b0, `LC_CTRL_ADDR, 32'h0000_0000, 4'hf);
			chk_reg(q, 32'h0000_0144);
			@(posedge ref_clk);
			{fast_sel, robust_sel} <= 2'b00;
			wr_ctrl(16'h0104, 4'h3);
			bus(1'b0, `LC_CTRL_ADDR, 32'h0000_0000, 4'hf);
			chk_reg(q, 32'h0000_0104);
		end
		tally_and_finish;
	end
endmodule
